/* hw/esu_defs.vh */
// constants for the exception state and type unit
`ifndef ESU_DEFS_VH
`define ESU_DEFS_VH
`define ESU_NUM_EXC 48
`define ESU_EXC_RESET 6'h01
`define ESU_EXC_NMI 6'h02
`define ESU_EXC_HARD 6'h03
`define ESU_EXC_SVC 6'h0b
`define ESU_EXC_PSV 6'h0e
`define ESU_EXC_TICK 6'h0f
`define ESU_EXC_IRQ0 6'h10
`define ESU_VEC_RESET 32'h00000004
`define ESU_VEC_NMI 32'h00000008
`define ESU_VEC_HARD 32'h0000000c
`define ESU_VEC_SVC 32'h0000002c
`define ESU_VEC_PSV 32'h00000038
`define ESU_VEC_TICK 32'h0000003c
`define ESU_VEC_IRQ0 32'h00000040
`define ESU_VEC_STEP 32'h00000004
// priorities as 3-bit ranks: 0..2 fixed (-3,-2,-1), 3..6 configurable 0,64,128,192
`define ESU_RANK_RESET 3'h0
`define ESU_RANK_NMI 3'h1
`define ESU_RANK_HARD 3'h2
`define ESU_RANK_CFG0 3'h3
`define ESU_RANK_NONE 3'h7
`endif

/* hw/esu_slot.v */
// state of one exception: pending and active bits
`timescale 1ns/100ps
module esu_slot (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // events
  input wire i_set_pend,
  input wire i_clr_pend,
  input wire i_enter,
  input wire i_retire,
  // state
  output wire o_pend,
  output wire o_act
);
  reg pend_reg;
  reg act_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
    end else begin
      // a new request in the entry or clear cycle stays pending
      if (i_set_pend)
        pend_reg <= 1'b1;
      else if (i_enter || i_clr_pend)
        pend_reg <= 1'b0;
      if (i_enter)
        act_reg <= 1'b1;
      else if (i_retire)
        act_reg <= 1'b0;
    end
  end
  assign o_pend = pend_reg;
  assign o_act = act_reg;
endmodule

/* hw/esu_sync.v */
// two-flop synchroniser for asynchronous request lines
`timescale 1ns/100ps
module esu_sync #(
  parameter W = 32
) (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // lines
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule

/* hw/esu_top.v */
// exception state tracking, type table and selection of the next exception
`timescale 1ns/100ps
`include "esu_defs.vh"
module esu_top #(
  parameter NIRQ = 32
) (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // request sources
  input wire [NIRQ-1:0] i_irq_line,
  input wire [NIRQ-1:0] i_irq_set_pend,
  input wire [NIRQ-1:0] i_irq_clr_pend,
  input wire i_nmi_line,
  input wire i_nmi_set_pend,
  input wire i_tick_zero,
  input wire i_tick_set_pend,
  input wire i_tick_clr_pend,
  input wire i_psv_set_pend,
  input wire i_psv_clr_pend,
  // enables and priorities from the configuration logic
  input wire [NIRQ-1:0] i_irq_enable,
  input wire [2*NIRQ-1:0] i_irq_prio,
  input wire [1:0] i_svc_prio,
  input wire [1:0] i_psv_prio,
  input wire [1:0] i_tick_prio,
  input wire i_mask_all,
  // pipeline side
  input wire i_svc_exec,
  input wire i_exc_error,
  input wire i_entry_done,
  input wire i_late_arrival,
  input wire i_exc_return,
  // outputs to pipeline
  output wire o_take,
  output reg [5:0] o_take_num,
  output reg [31:0] o_take_vector,
  output reg [5:0] o_status_num,
  output reg o_thread_mode,
  output reg [31:0] o_reset_vector,
  output wire [`ESU_NUM_EXC-1:0] o_pending,
  output wire [`ESU_NUM_EXC-1:0] o_active
);
  localparam ST_RUN = 2'h0;
  localparam ST_ENTRY = 2'h1;
  localparam ST_RESET = 2'h2;

  // ****************************************
  // request inputs
  // ****************************************
  wire [NIRQ-1:0] irq_s;
  wire nmi_s;
  wire tick_s;
  esu_sync #(.W(NIRQ+2)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_nmi_line, i_tick_zero, i_irq_line}),
    .o_sync({nmi_s, tick_s, irq_s})
  );
  reg nmi_d_reg;
  reg tick_d_reg;
  reg [NIRQ-1:0] irq_d_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [5:0] cand_reg;
  reg [5:0] stack_reg [0:7];
  reg [2:0] depth_reg;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nmi_d_reg <= 1'b0;
      tick_d_reg <= 1'b0;
      irq_d_reg <= {NIRQ{1'b0}};
    end else begin
      nmi_d_reg <= nmi_s;
      tick_d_reg <= tick_s;
      irq_d_reg <= irq_s;
    end
  end

  // rising edges, so a held line does not re-pend its own running handler
  wire nmi_rise;
  wire tick_rise;
  wire [NIRQ-1:0] irq_rise;
  assign nmi_rise = nmi_s && !nmi_d_reg;
  assign tick_rise = tick_s && !tick_d_reg;
  assign irq_rise = irq_s & ~irq_d_reg;

  // ****************************************
  // set and clear per exception
  // ****************************************
  reg [`ESU_NUM_EXC-1:0] set_v;
  reg [`ESU_NUM_EXC-1:0] clr_v;
  reg [`ESU_NUM_EXC-1:0] ent_v;
  reg [`ESU_NUM_EXC-1:0] ret_v;
  wire [5:0] top_num;
  wire entering;
  wire returning;
  assign top_num = stack_reg[depth_reg - 3'h1];
  assign entering = (state_reg == ST_ENTRY) && i_entry_done && !i_late_arrival;
  assign returning = i_exc_return && (depth_reg != 3'h0) && !entering;
  integer k;
  always @* begin
    set_v = {`ESU_NUM_EXC{1'b0}};
    clr_v = {`ESU_NUM_EXC{1'b0}};
    ent_v = {`ESU_NUM_EXC{1'b0}};
    ret_v = {`ESU_NUM_EXC{1'b0}};
    set_v[`ESU_EXC_NMI] = nmi_rise || i_nmi_set_pend;
    set_v[`ESU_EXC_HARD] = i_exc_error;
    set_v[`ESU_EXC_SVC] = i_svc_exec;
    set_v[`ESU_EXC_PSV] = i_psv_set_pend;
    set_v[`ESU_EXC_TICK] = tick_rise || i_tick_set_pend;
    clr_v[`ESU_EXC_PSV] = i_psv_clr_pend;
    clr_v[`ESU_EXC_TICK] = i_tick_clr_pend;
    for (k = 0; k < NIRQ; k = k + 1) begin
      set_v[16+k] = irq_rise[k] || i_irq_set_pend[k];
      clr_v[16+k] = i_irq_clr_pend[k];
    end
    if (entering)
      ent_v[cand_reg] = 1'b1;
    if (returning)
      ret_v[top_num] = 1'b1;
  end

  wire [`ESU_NUM_EXC-1:0] pend_w;
  wire [`ESU_NUM_EXC-1:0] act_w;
  genvar g;
  generate
    for (g = 0; g < `ESU_NUM_EXC; g = g + 1) begin : g_slot
      if (g == 0 || (g >= 4 && g <= 10) || g == 12 || g == 13) begin : g_rsv
        assign pend_w[g] = 1'b0;
        assign act_w[g] = 1'b0;
      end else begin : g_use
        esu_slot u_slot (
          .i_clk(i_clk),
          .i_rstn(i_rstn),
          .i_set_pend(set_v[g]),
          .i_clr_pend(clr_v[g]),
          .i_enter(ent_v[g]),
          .i_retire(ret_v[g]),
          .o_pend(pend_w[g]),
          .o_act(act_w[g])
        );
      end
    end
  endgenerate
  assign o_pending = pend_w;
  assign o_active = act_w;

  // ****************************************
  // priority and selection
  // ****************************************
  function [2:0] rank_of;
    input [5:0] n;
    input [1:0] svc_p;
    input [1:0] psv_p;
    input [1:0] tick_p;
    input [2*NIRQ-1:0] irq_p;
    input [NIRQ-1:0] en;
    reg [5:0] idx;
    begin
      idx = n - `ESU_EXC_IRQ0;
      case (n)
        `ESU_EXC_RESET: rank_of = `ESU_RANK_RESET;
        `ESU_EXC_NMI: rank_of = `ESU_RANK_NMI;
        `ESU_EXC_HARD: rank_of = `ESU_RANK_HARD;
        `ESU_EXC_SVC: rank_of = `ESU_RANK_CFG0 + {1'b0, svc_p};
        `ESU_EXC_PSV: rank_of = `ESU_RANK_CFG0 + {1'b0, psv_p};
        `ESU_EXC_TICK: rank_of = `ESU_RANK_CFG0 + {1'b0, tick_p};
        default: begin
          if (n >= `ESU_EXC_IRQ0 && idx < NIRQ && en[idx[4:0]])
            rank_of = `ESU_RANK_CFG0 + {1'b0, irq_p[2*idx[4:0] +: 2]};
          else
            rank_of = `ESU_RANK_NONE;
        end
      endcase
    end
  endfunction

  reg [2:0] best_rank;
  reg [5:0] best_num;
  reg [2:0] r;
  reg [2:0] cur_rank;
  integer j;
  always @*begin
    best_rank = `ESU_RANK_NONE;
    best_num = 6'h00;
    r = `ESU_RANK_NONE;
    // ascending scan with strict compare keeps the lowest number on ties
    for (j = 1; j < `ESU_NUM_EXC; j = j + 1) begin
      r = rank_of(j[5:0], i_svc_prio, i_psv_prio, i_tick_prio, i_irq_prio, i_irq_enable);
      if (i_mask_all && r >= `ESU_RANK_CFG0)
        r = `ESU_RANK_NONE;
      if (pend_w[j] && r < best_rank) begin
        best_rank = r;
        best_num = j[5:0];
      end
    end
    cur_rank = (depth_reg == 3'h0) ? `ESU_RANK_NONE :
      // a running handler keeps its rank even if its line is disabled meanwhile
      rank_of(top_num, i_svc_prio, i_psv_prio, i_tick_prio, i_irq_prio, {NIRQ{1'b1}});
  end
  // preempt only if strictly more urgent than the running handler
  wire can_take;
  assign can_take = (best_rank != `ESU_RANK_NONE) && (best_rank < cur_rank) && (depth_reg != 3'h7);

  // ****************************************
  // entry sequencer
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = ST_RUN;
      ST_RUN: if (can_take) state_next = ST_ENTRY;
      ST_ENTRY: if (i_entry_done && !i_late_arrival) state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end
  assign o_take = (state_reg == ST_ENTRY);

  // late arrival re-selects the vector without touching pending bits
  wire select_now;
  assign select_now = (state_reg == ST_RUN && can_take) ||
    (state_reg == ST_ENTRY && i_late_arrival && can_take);

  // ****************************************
  // vector offsets
  // ****************************************
  function [31:0] vector_of;
    input [5:0] n;
    reg [5:0] idx;
    begin
      idx = n - `ESU_EXC_IRQ0;
      case (n)
        `ESU_EXC_RESET: vector_of = `ESU_VEC_RESET;
        `ESU_EXC_NMI: vector_of = `ESU_VEC_NMI;
        `ESU_EXC_HARD: vector_of = `ESU_VEC_HARD;
        `ESU_EXC_SVC: vector_of = `ESU_VEC_SVC;
        `ESU_EXC_PSV: vector_of = `ESU_VEC_PSV;
        `ESU_EXC_TICK: vector_of = `ESU_VEC_TICK;
        default: vector_of = `ESU_VEC_IRQ0 + {24'h000000, idx, 2'b00};
      endcase
    end
  endfunction

  // ****************************************
  // state and selection registers
  // ****************************************
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_RESET;
      cand_reg <= 6'h00;
      o_take_num <= 6'h00;
      o_take_vector <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      if (select_now) begin
        cand_reg <= best_num;
        o_take_num <= best_num;
        o_take_vector <= vector_of(best_num);
      end
    end
  end

  // ****************************************
  // nest stack
  // ****************************************
  integer m;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      depth_reg <= 3'h0;
      for (m = 0; m < 8; m = m + 1)
        stack_reg[m] <= 6'h00;
    end else begin
      if (entering) begin
        stack_reg[depth_reg] <= cand_reg;
        depth_reg <= depth_reg + 3'h1;
      end else if (returning) begin
        depth_reg <= depth_reg - 3'h1;
      end
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status_num <= 6'h00;
      o_thread_mode <= 1'b1;
      o_reset_vector <= `ESU_VEC_RESET;
    end else begin
      if (entering) begin
        o_status_num <= cand_reg;
        o_thread_mode <= 1'b0;
      end else if (returning) begin
        o_status_num <= (depth_reg == 3'h1) ? 6'h00 : stack_reg[depth_reg - 3'h2];
        o_thread_mode <= (depth_reg == 3'h1);
      end
    end
  end
endmodule

/* verif/esu_pipe_model.sv */
// pipeline model that completes exception entry
`timescale 1ns/100ps
module esu_pipe_model (
  // clock
  input wire i_clk,
  // control
  input wire i_take,
  input wire i_hold,
  input wire i_late,
  // entry result
  output reg o_entry_done,
  output wire o_late_arrival
);
  // ****************************************
  // entry
  // ****************************************
  assign o_late_arrival = o_entry_done && i_late;
  initial o_entry_done = 1'b0;
  // one pulse per request, only while take is up
  always @(posedge i_clk) begin
    o_entry_done <= i_take && !i_hold && !o_entry_done;
  end
endmodule

/* verif/esu_top_sva.sv */
// assertions on the ports of the exception unit
`timescale 1ns/100ps
module esu_top_sva #(
  parameter NIRQ = 32
) (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // watched signals
  input wire [NIRQ-1:0] i_irq_set_pend,
  input wire i_entry_done,
  input wire i_late_arrival,
  input wire o_take,
  input wire [5:0] o_take_num,
  input wire [31:0] o_take_vector,
  input wire [5:0] o_status_num,
  input wire o_thread_mode,
  input wire [31:0] o_reset_vector,
  input wire [47:0] o_pending,
  input wire [47:0] o_active
);
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  AST_RST_VEC: assert property (o_reset_vector == 32'h00000004)
    else $error("reset vector wrong");
  AST_THREAD: assert property (o_thread_mode == (o_status_num == 6'h00))
    else $error("thread mode and status disagree");
  AST_VEC: assert property (o_take |-> o_take_vector == {24'h000000, o_take_num, 2'b00})
    else $error("vector does not match number");
  AST_RSVD_NUM: assert property (o_take |-> !(o_take_num inside {[4:10], 12, 13}))
    else $error("reserved number taken");
  AST_RSVD_ST: assert property (((o_pending[13:4] | o_active[13:4]) & 10'h37f) == 10'h000)
    else $error("reserved state set");
  AST_SET_PEND: assert property (i_irq_set_pend[0] |=> o_pending[16])
    else $error("software request not pending");
  AST_ENTER: assert property (o_take && i_entry_done && !i_late_arrival |=>
    o_active[$past(o_take_num)] && o_status_num == $past(o_take_num))
    else $error("entry did not activate");
  AST_HOLD: assert property (o_take && !i_entry_done |=> o_take)
    else $error("take dropped before entry");
  AST_LATE: assert property (o_take && i_entry_done && i_late_arrival |=> o_take)
    else $error("late arrival ended the entry");
  AST_NUM_HOLD: assert property (o_take && !i_late_arrival |=>
    !o_take || $stable(o_take_num))
    else $error("entry number changed without late arrival");
  COV_LATE: cover property (o_take && i_entry_done && i_late_arrival);
  COV_NMI: cover property (o_take && o_take_num == 6'h02);
  COV_NEST: cover property (o_active[16] && o_active[17]);
  COV_ACT_PEND: cover property (o_active[17] && o_pending[17]);
endmodule
bind esu_top esu_top_sva #(.NIRQ(NIRQ)) sva_u (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_irq_set_pend(i_irq_set_pend), .i_entry_done(i_entry_done),
  .i_late_arrival(i_late_arrival), .o_take(o_take), .o_take_num(o_take_num),
  .o_take_vector(o_take_vector), .o_status_num(o_status_num),
  .o_thread_mode(o_thread_mode), .o_reset_vector(o_reset_vector),
  .o_pending(o_pending), .o_active(o_active));

/* verif/esu_top_tb.sv */
// self-checking bench for the exception unit
`timescale 1ns/100ps
`include "esu_defs.vh"
module esu_top_tb;
  // ****************************************
  // signals
  // ****************************************
  reg i_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg [31:0] line = 32'h0, spend = 32'h0, cpend = 32'h0, en = 32'hffffffff;
  reg [63:0] prio = 64'h0;
  reg nmi = 0, nmi_sw = 0, tz = 0, tset = 0, pset = 0, mask = 0, supervisor_call_instruction = 0, err = 0;
  reg ret_p = 0, hold = 0, late_rq = 0, tclr = 0, pclr = 0;
  reg [1:0] sp = 2'h0, pp = 2'h0, tp = 2'h0;
  wire take, thr, done, late;
  wire [5:0] num, stat;
  wire [31:0] vec, rvec;
  wire [47:0] pend, act;
  integer n_mismatch = 0, samples_checked = 0;
  always #10 i_clk = ~i_clk;
  esu_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_irq_line(line), .i_irq_set_pend(spend),
    .i_irq_clr_pend(cpend), .i_nmi_line(nmi), .i_nmi_set_pend(nmi_sw), .i_tick_zero(tz),
    .i_tick_set_pend(tset), .i_tick_clr_pend(tclr), .i_psv_set_pend(pset),
    .i_psv_clr_pend(pclr), .i_irq_enable(en), .i_irq_prio(prio), .i_svc_prio(sp),
    .i_psv_prio(pp), .i_tick_prio(tp), .i_mask_all(mask), .i_svc_exec(supervisor_call_instruction),
    .i_exc_error(err), .i_entry_done(done), .i_late_arrival(late), .i_exc_return(ret_p),
    .o_take(take), .o_take_num(num), .o_take_vector(vec), .o_status_num(stat),
    .o_thread_mode(thr), .o_reset_vector(rvec), .o_pending(pend), .o_active(act));
  esu_pipe_model pipe_u (.i_clk(i_clk), .i_take(take), .i_hold(hold), .i_late(late_rq),
    .o_entry_done(done), .o_late_arrival(late));
  // ****************************************
  // helpers
  // ****************************************
  task chk(input [47:0] got, input [47:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge i_clk);
  endtask
  function [31:0] vec_of(input [5:0] n);
    case (n)
      6'h02: vec_of = `ESU_VEC_NMI;
      6'h03: vec_of = `ESU_VEC_HARD;
      6'h0b: vec_of = `ESU_VEC_SVC;
      6'h0e: vec_of = `ESU_VEC_PSV;
      6'h0f: vec_of = `ESU_VEC_TICK;
      default: vec_of = `ESU_VEC_IRQ0 + `ESU_VEC_STEP * (n - 6'h10);
    endcase
  endfunction
  task take_chk(input [5:0] n);
    integer i;
    begin
      for (i = 0; take !== 1'b1 && i < 20; i = i + 1) cyc(1);
      chk(take, 1'b1);
      chk(num, n);
      chk(vec, vec_of(n));
      for (i = 0; stat !== n && i < 20; i = i + 1) cyc(1);
      chk(stat, n);
      chk(act[n], 1'b1);
    end
  endtask
  task ret;
    begin
      ret_p = 1;
      cyc(1);
      ret_p = 0;
      cyc(1);
    end
  endtask
  task irq(input [31:0] m);
    begin
      spend = m;
      cyc(1);
      spend = 0;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    begin
      i_rstn = 0;
      cyc(2);
      chk(pend | act, 48'h0);
      chk({thr, stat, take}, 8'h80);
      chk(rvec, `ESU_VEC_RESET);
      i_rstn = 1;
      cyc(2);
    end
  endtask
  task t_irq;
    begin
      hold = 1;
      irq(32'h1);
      chk(pend[16], 1'b1);
      hold = 0;
      take_chk(6'h10);
      chk(thr, 1'b0);
      ret;
      chk({act[16], thr}, 2'b01);
    end
  endtask
  task t_fixed;
    integer k;
    reg [5:0] n;
    for (k = 0; k < 6; k = k + 1) begin
      case (k)
        0: begin nmi_sw = 1; n = 6'h02; end
        1: begin err = 1; n = 6'h03; end
        2: begin supervisor_call_instruction = 1; n = 6'h0b; end
        3: begin pset = 1; n = 6'h0e; end
        4: begin tset = 1; n = 6'h0f; end
        default: begin tz = 1; n = 6'h0f; end
      endcase
      cyc(1);
      {nmi_sw, err, supervisor_call_instruction, pset, tset} = 5'h00;
      take_chk(n);
      ret;
      tz = 0;
      chk(thr, 1'b1);
    end
  endtask
  task t_nest;
    begin
      prio[1:0] = 2'h1;
      irq(32'h1);
      take_chk(6'h10);
      irq(32'h2);
      take_chk(6'h11);
      chk(act[16], 1'b1);
      hold = 1;
      irq(32'h2);
      cyc(1);
      chk({pend[17], act[17]}, 2'b11);
      hold = 0;
      ret;
      take_chk(6'h11);
      ret;
      ret;
      chk(thr, 1'b1);
      hold = 1;
      irq(32'h1);
      t_reset;
      hold = 0;
      prio = 64'h0;
    end
  endtask
  task t_equal;
    begin
      hold = 1;
      irq(32'hc);
      cyc(1);
      chk({take, num}, 7'h52);
      hold = 0;
      take_chk(6'h12);
      cyc(3);
      chk(stat, 6'h12);
      cpend = 32'h8;
      cyc(1);
      cpend = 0;
      ret;
      cyc(4);
      chk({take, pend[19]}, 2'b00);
    end
  endtask
  task t_mask;
    begin
      mask = 1;
      irq(32'h10);
      cyc(4);
      chk(take, 1'b0);
      nmi = 1;
      take_chk(6'h02);
      ret;
      {nmi, mask} = 2'b00;
      take_chk(6'h14);
      ret;
      en[6] = 0;
      irq(32'h40);
      cyc(4);
      chk(take, 1'b0);
      en[6] = 1;
      take_chk(6'h16);
      ret;
      line[5] = 1;
      take_chk(6'h15);
      ret;
      line = 0;
    end
  endtask
  task t_cfg;
    begin
      {sp, pp, tp} = 6'h36;
      {supervisor_call_instruction, tset, pset} = 3'h7;
      irq(32'h1);
      {supervisor_call_instruction, tset, pset} = 3'h0;
      take_chk(6'h10);
      ret;
      take_chk(6'h0e);
      ret;
      take_chk(6'h0f);
      ret;
      take_chk(6'h0b);
      ret;
      mask = 1;
      {tset, pset} = 2'h3;
      cyc(1);
      chk({pend[15], pend[14]}, 2'b11);
      {tset, pset, tclr, pclr} = 4'h3;
      cyc(1);
      {tclr, pclr} = 2'h0;
      chk({pend[15], pend[14]}, 2'b00);
      mask = 0;
      cyc(3);
      chk(take, 1'b0);
      {sp, pp, tp} = 6'h00;
    end
  endtask
  task t_late;
    begin
      prio[1:0] = 2'h1;
      hold = 1;
      irq(32'h1);
      irq(32'h2);
      chk({take, num}, 7'h50);
      {late_rq, hold} = 2'b10;
      cyc(2);
      chk({take, num, vec}, {1'b1, 6'h11, vec_of(6'h11)});
      late_rq = 0;
      take_chk(6'h11);
      chk(pend[16], 1'b1);
      ret;
      take_chk(6'h10);
      ret;
      prio = 64'h0;
    end
  endtask
  // ****************************************
  // run
  // ****************************************
  task close_out;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    cyc(16);
    i_rstn = 1;
    cyc(2);
    t_irq;
    t_fixed;
    t_nest;
    t_equal;
    t_cfg;
    t_late;
    t_mask;
    t_reset;
    close_out;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
